// *** hdl/smbcfg_pkg.sv ***
// constants and types shared by the configuration slave
package smbcfg_pkg;
  // ==========================================================
  // serial address and command code layout
  localparam logic [6:0] SLAVE_ADDR7 = 7'h69;
  localparam int CMD_MODE_BIT = 7;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  // idle levels of the synchronised pins, bit order strap, strobe, data, clock
  localparam logic [3:0] PIN_IDLE = 4'h3;
  // ==========================================================
  // configuration byte map
  localparam int NUM_BYTES = 8;
  localparam logic [7:0] BLOCK_COUNT = 8'h08;
  localparam logic [7:0] UNMAPPED_READ = 8'hFF;
  localparam int FS_BIT = 7;
  // identity byte: value is arbitrary
  localparam logic [7:0] ID_BYTE = 8'h5A;
  localparam logic [7:0] REG_RST [0:NUM_BYTES-1] = '{
    8'h21, 8'h85, 8'hFF, 8'hFF, 8'hFF, 8'h00, 8'h00, ID_BYTE};
  localparam logic [7:0] REG_WMASK [0:NUM_BYTES-1] = '{
    8'h7F, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h00};
  // ==========================================================
  // serial engine states
  typedef enum logic [2:0] {
    S_IDLE,
    S_RX,
    S_RX_ACK,
    S_TX,
    S_TX_ACK,
    S_WAIT
  } smbcfg_state_e;
endpackage

// *** hdl/smbcfg_sync.sv ***
// two-flop synchronisers with edge detection for the pin inputs
`timescale 1ns/10ps
module smbcfg_sync
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // raw pins
  input wire logic [3:0] pin_in,
  // synchronised levels and edges
  output logic [3:0] lvl,
  output logic [3:0] rise,
  output logic [3:0] fall
);
  // ==========================================================
  // per-pin chain
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1)
    begin : g_pin
      logic meta_ff;
      logic sync_ff;
      logic prev_ff;
      // first stage feeds only the second
      always_ff @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          // start at the idle level so leaving reset makes no false edge
          meta_ff <= smbcfg_pkg::PIN_IDLE[gi];
          sync_ff <= smbcfg_pkg::PIN_IDLE[gi];
          prev_ff <= smbcfg_pkg::PIN_IDLE[gi];
        end
        else
        begin
          meta_ff <= pin_in[gi];
          sync_ff <= meta_ff;
          prev_ff <= sync_ff;
        end
      end
      assign lvl[gi] = sync_ff;
      assign rise[gi] = sync_ff & ~prev_ff;
      assign fall[gi] = ~sync_ff & prev_ff;
    end
  endgenerate
endmodule

// *** hdl/smbcfg_top.sv ***
// frequency-select latch and serial configuration slave
// What this block does
// - strap sampled once at first power-good high; later changes ignored outside test.
// - latched 0 means 133MHz, 1 means 100MHz; readable as byte 0 bit 7.
// - after power-good, a low on the same pin requests power-down.
// - configuration bytes keep their contents during power-down.
// - every configuration byte takes its default at power-up.
// - configuration bits enable or disable output buffers and other functions.
// - slave supports byte write, byte read, block write and block read.
// - block bytes move upward from the lowest, msb first, stoppable anytime.
// - slave answers only address bytes 11010010 (write) and 11010011 (read).
// - command bit 7 low means block access, high means single byte.
// - single-byte offset comes from command bits 6 to 0.
// - block write is address, command, count, data bytes, all acknowledged.
// - block read: command, repeated start, read address, then slave sends count.
// - host acks count and data, nacks the last byte, then stops.
// - byte write is address, command, one data byte, then stop.
// - byte read returns one byte, host nacks, then stops.
`timescale 1ns/10ps
module smbcfg_top
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // serial interface
  input wire logic scl_in,
  input wire logic serial_data_line_in,
  output logic serial_data_line_out,
  output logic serial_data_line_oe,
  // straps and power control
  input wire logic freq_select_strap,
  input wire logic power_good_or_powerdown_pin,
  input wire logic test_mode,
  output logic fs_latched,
  output logic power_down_request,
  // configuration image, byte n at bits 8n+7:8n
  output logic [8*smbcfg_pkg::NUM_BYTES-1:0] cfg_image
);
  import smbcfg_pkg::*;
  // ==========================================================
  // synchronised pins
  logic [3:0] lvl;
  logic [3:0] rise;
  logic [3:0] fall;
  smbcfg_sync u_sync
  (
    .clk(clk),
    .rst_n(rst_n),
    .pin_in({freq_select_strap, power_good_or_powerdown_pin, serial_data_line_in, scl_in}),
    .lvl(lvl),
    .rise(rise),
    .fall(fall)
  );
  logic scl_s;
  logic sda_s;
  logic pg_s;
  logic fs_s;
  logic start_det;
  logic stop_det;
  assign scl_s = lvl[0];
  assign sda_s = lvl[1];
  assign pg_s = lvl[2];
  assign fs_s = lvl[3];
  assign start_det = fall[1] & scl_s;
  assign stop_det = rise[1] & scl_s;
  // ==========================================================
  // frequency-select latch and power-down
  logic pg_seen_ff;
  logic fs_latched_ff;
  logic pd_ff;
  logic tm_meta_ff;
  logic tm_s_ff;
  // test strap is a pin too: two flops before the latch reads it
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tm_meta_ff <= 1'b0;
      tm_s_ff <= 1'b0;
    end
    else
    begin
      tm_meta_ff <= test_mode;
      tm_s_ff <= tm_meta_ff;
    end
  end
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pg_seen_ff <= 1'b0;
      fs_latched_ff <= 1'b0;
    end
    else if (pg_s && (!pg_seen_ff || tm_s_ff))
    begin
      pg_seen_ff <= 1'b1;
      fs_latched_ff <= fs_s;
    end
  end
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      pd_ff <= 1'b0;
    else
      pd_ff <= pg_seen_ff & ~pg_s;
  end
  assign fs_latched = fs_latched_ff;
  assign power_down_request = pd_ff;
  // ==========================================================
  // serial engine
  smbcfg_state_e state_ff;
  logic [3:0] bit_cnt_ff;
  logic [1:0] idx_ff;
  logic [7:0] rx_sh_ff;
  logic [7:0] tx_sh_ff;
  logic read_ff;
  logic oe_ff;
  logic byte_mode_ff;
  logic count_sent_ff;
  logic [6:0] ptr_ff;
  logic [7:0] cfg_ff [0:NUM_BYTES-1];
  logic byte_end;
  logic addr_ok;
  logic byte_done;
  logic tx_load;
  logic wr_en;
  logic [7:0] rd_byte;
  logic [7:0] tx_byte;
  assign byte_end = (state_ff == S_RX) && fall[0] && (bit_cnt_ff == BITS_PER_BYTE);
  assign addr_ok = (idx_ff != 2'h0) || (rx_sh_ff[7:1] == SLAVE_ADDR7);
  assign byte_done = byte_end && addr_ok && !start_det && !stop_det;
  assign tx_load = !start_det && !stop_det && fall[0]
    && (((state_ff == S_RX_ACK) && read_ff) || (state_ff == S_TX_ACK));
  assign wr_en = byte_done && !read_ff && ((idx_ff == 2'h3) || ((idx_ff == 2'h2) && byte_mode_ff));
  assign rd_byte = (ptr_ff < 7'(NUM_BYTES)) ? cfg_image[8*ptr_ff[2:0] +: 8] : UNMAPPED_READ;
  assign tx_byte = (!byte_mode_ff && !count_sent_ff) ? BLOCK_COUNT : rd_byte;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_ff <= S_IDLE;
      bit_cnt_ff <= 4'h0;
      idx_ff <= 2'h0;
      rx_sh_ff <= 8'h00;
      tx_sh_ff <= 8'h00;
      read_ff <= 1'b0;
      oe_ff <= 1'b0;
    end
    else if (start_det)
    begin
      state_ff <= S_RX;
      bit_cnt_ff <= 4'h0;
      idx_ff <= 2'h0;
      oe_ff <= 1'b0;
    end
    else if (stop_det)
    begin
      state_ff <= S_IDLE;
      oe_ff <= 1'b0;
    end
    else
    begin
      case (state_ff)
        S_RX:
        begin
          if (rise[0] && bit_cnt_ff != BITS_PER_BYTE)
          begin
            rx_sh_ff <= {rx_sh_ff[6:0], sda_s};
            bit_cnt_ff <= bit_cnt_ff + 4'h1;
          end
          else if (byte_end)
          begin
            // match own address or stay released
            if (!addr_ok)
              state_ff <= S_WAIT;
            else
            begin
              oe_ff <= 1'b1;
              state_ff <= S_RX_ACK;
              if (idx_ff == 2'h0)
                read_ff <= rx_sh_ff[0];
              if (idx_ff != 2'h3)
                idx_ff <= idx_ff + 2'h1;
            end
          end
        end
        S_RX_ACK:
        begin
          if (fall[0])
          begin
            bit_cnt_ff <= 4'h0;
            if (read_ff)
            begin
              tx_sh_ff <= tx_byte;
              oe_ff <= ~tx_byte[7];
              state_ff <= S_TX;
            end
            else
            begin
              oe_ff <= 1'b0;
              state_ff <= S_RX;
            end
          end
        end
        S_TX:
        begin
          if (rise[0])
            bit_cnt_ff <= bit_cnt_ff + 4'h1;
          else if (fall[0])
          begin
            if (bit_cnt_ff == BITS_PER_BYTE)
            begin
              oe_ff <= 1'b0;
              state_ff <= S_TX_ACK;
            end
            else
            begin
              oe_ff <= ~tx_sh_ff[6];
              tx_sh_ff <= {tx_sh_ff[6:0], 1'b0};
            end
          end
        end
        S_TX_ACK:
        begin
          // nack from host ends the read
          if (rise[0] && sda_s)
            state_ff <= S_WAIT;
          else if (fall[0])
          begin
            tx_sh_ff <= tx_byte;
            oe_ff <= ~tx_byte[7];
            bit_cnt_ff <= 4'h0;
            state_ff <= S_TX;
          end
        end
        default:
          oe_ff <= 1'b0;
      endcase
    end
  end
  assign serial_data_line_out = 1'b0;
  assign serial_data_line_oe = oe_ff;
  // ==========================================================
  // command decode and byte pointer
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      byte_mode_ff <= 1'b0;
      ptr_ff <= 7'h00;
      count_sent_ff <= 1'b0;
    end
    else
    begin
      if (start_det)
        count_sent_ff <= 1'b0;
      else if (tx_load && !byte_mode_ff && !count_sent_ff)
        count_sent_ff <= 1'b1;
      if (byte_done && idx_ff == 2'h1)
      begin
        byte_mode_ff <= rx_sh_ff[CMD_MODE_BIT];
        ptr_ff <= rx_sh_ff[CMD_MODE_BIT] ? rx_sh_ff[6:0] : 7'h00;
      end
      else if (wr_en || (tx_load && (byte_mode_ff || count_sent_ff)))
        ptr_ff <= ptr_ff + 7'h01;
    end
  end
  // ==========================================================
  // configuration bytes, not touched by power-down
  // defaults and byte writes masked by REG_WMASK
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < NUM_BYTES; i++)
        cfg_ff[i] <= REG_RST[i];
    end
    else if (wr_en && ptr_ff < 7'(NUM_BYTES))
      cfg_ff[ptr_ff[2:0]] <= (cfg_ff[ptr_ff[2:0]] & ~REG_WMASK[ptr_ff[2:0]])
        | (rx_sh_ff & REG_WMASK[ptr_ff[2:0]]);
  end
  genvar gb;
  generate
    for (gb = 0; gb < NUM_BYTES; gb = gb + 1)
    begin : g_img
      if (gb == 0)
        assign cfg_image[7:0] = {fs_latched_ff, cfg_ff[0][6:0]};
      else
        assign cfg_image[8*gb +: 8] = cfg_ff[gb];
    end
  endgenerate
  // ==========================================================
  // checks
  fs_held_a: assert property (@(posedge clk) disable iff (!rst_n)
    (pg_seen_ff && !tm_s_ff) |=> $stable(fs_latched_ff) && pg_seen_ff)
    else $error("strap latch changed after power-good");
  pd_follow_a: assert property (@(posedge clk) disable iff (!rst_n)
    (pg_seen_ff && !pg_s) |=> power_down_request)
    else $error("power-down request missing");
  fs_bit_a: assert property (@(posedge clk) disable iff (!rst_n)
    cfg_image[FS_BIT] == fs_latched && fs_latched == fs_latched_ff)
    else $error("frequency bit not visible in byte 0");
  foreign_nack_a: assert property (@(posedge clk) disable iff (!rst_n)
    (byte_end && !addr_ok && !start_det && !stop_det) |=> ((state_ff == S_WAIT) && !oe_ff) [*2])
    else $error("foreign address acknowledged");
  own_ack_a: assert property (@(posedge clk) disable iff (!rst_n)
    (byte_done && idx_ff == 2'h0) |=> oe_ff && (state_ff == S_RX_ACK))
    else $error("own address not acknowledged");
  stop_abort_a: assert property (@(posedge clk) disable iff (!rst_n)
    (stop_det && !start_det) |=> (state_ff == S_IDLE) && !serial_data_line_oe
      && $stable(cfg_image))
    else $error("stop did not abort cleanly");
  cmd_offset_a: assert property (@(posedge clk) disable iff (!rst_n)
    (byte_done && idx_ff == 2'h1) |=> byte_mode_ff == $past(rx_sh_ff[7])
      && ptr_ff == ($past(rx_sh_ff[7]) ? $past(rx_sh_ff[6:0]) : 7'h00))
    else $error("command decode wrong");
  ptr_step_a: assert property (@(posedge clk) disable iff (!rst_n)
    wr_en |=> ptr_ff == $past(ptr_ff) + 7'h01)
    else $error("pointer did not advance");
  count_first_a: assert property (@(posedge clk) disable iff (!rst_n)
    (tx_load && !byte_mode_ff && !count_sent_ff) |=> tx_sh_ff == BLOCK_COUNT)
    else $error("block read did not start with count");
  host_nack_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state_ff == S_TX_ACK && rise[0] && sda_s && !start_det && !stop_det)
      |=> (state_ff == S_WAIT) ##1 !serial_data_line_oe)
    else $error("read continued after host nack");
endmodule

// *** verification/smbcfg_host_model.sv ***
// host-side serial master model: drives the clock and pulls data low
`timescale 1ns/10ps
module smbcfg_host_model
(
  // clock
  input wire logic clk,
  // serial wires
  input wire logic sda,
  output logic scl,
  output logic sda_oe
);
  initial
  begin
    scl = 1'b1;
    sda_oe = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  // msb first, data moved only while clock low
  task automatic bit_io(input logic b, output logic r);
    tick(1);
    sda_oe = !b;
    tick(4);
    scl = 1'b1;
    tick(2);
    r = sda;
    tick(1);
    scl = 1'b0;
  endtask
  // start or repeated start, waits out the slave ack release
  task automatic start();
    tick(1);
    sda_oe = 1'b0;
    tick(4);
    scl = 1'b1;
    tick(3);
    sda_oe = 1'b1;
    tick(3);
    scl = 1'b0;
  endtask
  task automatic stop();
    tick(1);
    sda_oe = 1'b1;
    tick(4);
    scl = 1'b1;
    tick(3);
    sda_oe = 1'b0;
    tick(4);
  endtask
  // host acks read bytes except the last
  task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q,
    output logic ack);
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], q[i]);
    bit_io(a, ack);
  endtask
endmodule

// *** verification/smbcfg_top_test.sv ***
// self-checking bench for the strap latch and configuration slave
`timescale 1ns/10ps
module smbcfg_top_test;
  import smbcfg_pkg::*;
  logic clk, rst_n, strap, pgood, test_mode, scl, host_oe, dut_oe, dut_out, fs, pdreq;
  logic [8*NUM_BYTES-1:0] img;
  logic [7:0] mem [0:NUM_BYTES-1];
  int num_errors = 0;
  int total_checks = 0;
  // open-drain wire with pull-up
  wire sda = !host_oe && (!dut_oe || dut_out);
  smbcfg_top u_smbcfg_top (.clk(clk), .rst_n(rst_n), .scl_in(scl),
    .serial_data_line_in(sda), .serial_data_line_out(dut_out), .serial_data_line_oe(dut_oe),
    .freq_select_strap(strap), .power_good_or_powerdown_pin(pgood),
    .test_mode(test_mode), .fs_latched(fs), .power_down_request(pdreq), .cfg_image(img));
  smbcfg_host_model u_smbcfg_host_model (.clk(clk), .sda(sda), .scl(scl), .sda_oe(host_oe));
  // ==========================================================
  // helpers
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_img();
    for (int i = 0; i < NUM_BYTES; i++)
      chk8(img[8*i+:8], mem[i]);
  endtask
  task automatic put(input logic [7:0] d, input logic nak);
    logic [7:0] q;
    logic a;
    u_smbcfg_host_model.xfer(d, 1'b1, q, a);
    chk8({7'h00, a}, {7'h00, nak});
  endtask
  task automatic get(input logic last, input logic [7:0] e);
    logic [7:0] q;
    logic a;
    u_smbcfg_host_model.xfer(8'hFF, last, q, a);
    chk8(q, e);
  endtask
  task automatic wr(input logic [7:0] cmd, input logic [7:0] d[$]);
    u_smbcfg_host_model.start();
    put(8'hD2, 1'b0);
    put(cmd, 1'b0);
    foreach (d[i])
      put(d[i], 1'b0);
    u_smbcfg_host_model.stop();
  endtask
  task automatic rd(input logic [7:0] cmd, input logic [7:0] e[$]);
    u_smbcfg_host_model.start();
    put(8'hD2, 1'b0);
    put(cmd, 1'b0);
    u_smbcfg_host_model.start();
    put(8'hD3, 1'b0);
    foreach (e[i])
      get(i == e.size() - 1, e[i]);
    u_smbcfg_host_model.stop();
  endtask
  task automatic do_reset();
    rst_n = 1'b0;
    tick(16);
    rst_n = 1'b1;
    tick(4);
    for (int i = 0; i < NUM_BYTES; i++)
      mem[i] = REG_RST[i];
  endtask
  // ==========================================================
  // scenarios
  task automatic t_strap();
    chk_img();
    chk8({6'h00, fs, dut_oe}, 8'h00);
    // strap settled before the strobe rises
    strap = 1'b1;
    tick(4);
    pgood = 1'b1;
    tick(8);
    mem[0][7] = 1'b1;
    chk8({7'h00, fs}, 8'h01);
    chk_img();
    strap = 1'b0;
    pgood = 1'b0;
    tick(8);
    chk8({6'h00, fs, pdreq}, 8'h03);
    wr(8'h86, '{8'h5C});
    mem[6] = 8'h5C;
    chk_img();
    pgood = 1'b1;
    tick(8);
    chk8({6'h00, fs, pdreq}, 8'h02);
  endtask
  task automatic t_bytes();
    wr(8'h82, '{8'h3C});
    mem[2] = 8'h3C;
    chk_img();
    rd(8'h82, '{8'h3C});
    wr(8'h87, '{8'h00});
    wr(8'h80, '{8'h00});
    mem[0] = 8'h80;
    chk_img();
    rd(8'h87, '{REG_RST[7]});
    wr(8'h8A, '{8'h77});
    chk_img();
    rd(8'h8A, '{UNMAPPED_READ});
  endtask
  task automatic t_block();
    // block command carries zero offset bits
    wr(8'h00, '{8'h03, 8'h11, 8'h22, 8'h33});
    mem[0] = 8'h91;
    mem[1] = 8'h22;
    mem[2] = 8'h33;
    chk_img();
    rd(8'h00, '{8'h08, 8'h91, 8'h22, 8'h33});
  endtask
  task automatic t_faults();
    logic b;
    u_smbcfg_host_model.start();
    put(8'hA4, 1'b1);
    put(8'h00, 1'b1);
    u_smbcfg_host_model.stop();
    u_smbcfg_host_model.start();
    put(8'hD2, 1'b0);
    put(8'h85, 1'b0);
    for (int i = 0; i < 4; i++)
      u_smbcfg_host_model.bit_io(1'b0, b);
    u_smbcfg_host_model.stop();
    chk_img();
    rd(8'h85, '{mem[5]});
  endtask
  task automatic t_test_rst();
    test_mode = 1'b1;
    tick(8);
    chk8({7'h00, fs}, 8'h00);
    test_mode = 1'b0;
    strap = 1'b1;
    tick(8);
    chk8({7'h00, fs}, 8'h00);
    do_reset();
    // strobe already high at release, so the strap is captured again
    mem[0][7] = 1'b1;
    chk8({7'h00, fs}, 8'h01);
    chk_img();
  endtask
  task automatic final_report();
    if (num_errors == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // ==========================================================
  // run
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial
  begin
    strap = 1'b0;
    pgood = 1'b0;
    test_mode = 1'b0;
    do_reset();
    // registers set up by do_reset at start and again in t_test_rst; power control stays on the strobe pin
    t_strap();
    t_bytes();
    t_block();
    t_faults();
    t_test_rst();
    final_report();
  end
  // hang guard, several times the expected run
  initial
  begin
    repeat (30000) @(posedge clk);
    num_errors++;
    final_report();
  end
endmodule
